// [src/scg_gate.sv]
// Function
// [RULE1] a set enable clocks its unit, a clear one leaves it unclocked and disabled.
// [RULE2] any access to a gated-off unit is answered with a bus fault.
// [RULE3] reset clears the sleep gating register to all zeros.
// [RULE4] sleep register governs in sleep, run register in run, deep-sleep register in deep sleep.
// [RULE5] sleep settings apply only while the automatic gating select bit is set.
// [RULE6] bit 16 is the read/write usb controller enable, reset zero.
// [RULE7] bit 13 is the read/write dma controller enable, reset zero.
// [RULE8] bits 7..0 are read/write enables for ports h..a, bit 0 port a.
// [RULE9] bits 31:17, 15:14 and 12:8 are read-only zero.
// [RULE10] software must enable every unit it needs after reset.
// [RULE11] one enable source per unit, chosen from power state and the select bit.
module scg_gate (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // register port
  input  wire logic [11:0]               addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [31:0]               rdata,
  // power state from the system
  input  wire logic                      sleep_req,
  input  wire logic                      deep_req,
  // unit bus monitor: access strobe per unit
  input  wire logic [9:0]                unit_access,
  // gated clocks and results
  output logic      [9:0]                unit_clk,
  output logic      [9:0]                unit_en,
  output logic      [9:0]                unit_fault,
  output logic                           irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]        run_gate;
    logic [31:0]        sleep_gate;
    logic [31:0]        deep_gate;
    logic               auto_sel;
    logic [1:0]         sleep_s;
    logic [1:0]         deep_s;
    scg_pkg::scg_mode_t mode;
    logic [9:0]         fault;
    logic [9:0]         fault_info;
    logic [1:0]         irq_status;
    logic [1:0]         irq_mask;
    logic [31:0]        rdata;
  } scg_state_t;

  scg_state_t s_q;
  scg_state_t s_d;
  logic [9:0] en_now;
  logic [31:0] sel_gate;
  logic        clk_en_q [10];

  // pack unit enables: usb, dma, ports h..a
  function automatic logic [9:0] pick(input logic [31:0] g);
    pick = {g[scg_pkg::USB_BIT], g[scg_pkg::DMA_BIT], g[7:0]}; // [RULE6] [RULE7] [RULE8]
  endfunction

  // ----------------------------------------------------------------
  // enable source selection
  // ----------------------------------------------------------------
  always_comb
  begin
    // without the select bit, sleep states keep the run settings
    if (!s_q.auto_sel || s_q.mode == scg_pkg::SCG_RUN)
    begin
      sel_gate = s_q.run_gate; // [RULE5] [RULE11]
    end
    else if (s_q.mode == scg_pkg::SCG_SLEEP)
    begin
      sel_gate = s_q.sleep_gate; // [RULE4]
    end
    else
    begin
      sel_gate = s_q.deep_gate; // [RULE4]
    end
    en_now = pick(sel_gate);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.sleep_s = {s_q.sleep_s[0], sleep_req};
    s_d.deep_s  = {s_q.deep_s[0], deep_req};
    case ({s_q.deep_s[1], s_q.sleep_s[1]})
      2'b00:   s_d.mode = scg_pkg::SCG_RUN;
      2'b01:   s_d.mode = scg_pkg::SCG_SLEEP;
      default: s_d.mode = scg_pkg::SCG_DEEP;
    endcase
    if (s_d.mode != s_q.mode)
    begin
      s_d.irq_status[scg_pkg::IRQ_MODE_BIT] = 1'b1;
    end
    s_d.fault = unit_access & ~en_now; // [RULE2]
    s_d.rdata = 32'h0000_0000;
    if (rd)
    begin
      case (addr)
        scg_pkg::RUN_GATE_OFF:   s_d.rdata = s_q.run_gate;
        scg_pkg::SLEEP_GATE_OFF: s_d.rdata = s_q.sleep_gate;
        scg_pkg::DEEP_GATE_OFF:  s_d.rdata = s_q.deep_gate;
        scg_pkg::RUN_CFG_OFF:    s_d.rdata = 32'(s_q.auto_sel) << scg_pkg::AUTO_SEL_BIT;
        scg_pkg::IRQ_STATUS_OFF:
        begin
          s_d.rdata = {30'h0000_0000, s_q.irq_status};
          s_d.irq_status = 2'h0;
        end
        scg_pkg::IRQ_MASK_OFF:   s_d.rdata = {30'h0000_0000, s_q.irq_mask};
        scg_pkg::FAULT_INFO_OFF: s_d.rdata = {22'h00_0000, s_q.fault_info};
        default:                 s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      case (addr)
        scg_pkg::RUN_GATE_OFF:   s_d.run_gate = wdata & scg_pkg::GATE_WMASK;
        scg_pkg::SLEEP_GATE_OFF: s_d.sleep_gate = wdata & scg_pkg::GATE_WMASK; // [RULE9]
        scg_pkg::DEEP_GATE_OFF:  s_d.deep_gate = wdata & scg_pkg::GATE_WMASK;
        scg_pkg::RUN_CFG_OFF:    s_d.auto_sel = wdata[scg_pkg::AUTO_SEL_BIT];
        scg_pkg::IRQ_MASK_OFF:   s_d.irq_mask = wdata[1:0] & scg_pkg::IRQ_WMASK;
        default:                 s_d.irq_mask = s_d.irq_mask;
      endcase
    end
    // set beats the read-clear in the same cycle
    if (|s_d.fault)
    begin
      s_d.irq_status[scg_pkg::IRQ_FAULT_BIT] = 1'b1;
      s_d.fault_info = s_d.fault;
    end
    if (s_d.mode != s_q.mode)
    begin
      s_d.irq_status[scg_pkg::IRQ_MODE_BIT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q <= '0; // [RULE3]
      s_q.sleep_gate <= scg_pkg::GATE_RESET; // [RULE3]
      s_q.mode <= scg_pkg::SCG_RUN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // glitch-free clock gates, enable latched on the low phase
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 10; i++)
  begin : g_gate
    always_ff @(negedge clock)
    begin
      clk_en_q[i] <= en_now[i] & rst_n;
    end
    assign unit_clk[i] = clock & clk_en_q[i]; // [RULE1]
  end

  assign unit_en    = en_now; // [RULE1] [RULE10]
  assign unit_fault = s_q.fault;
  assign rdata      = s_q.rdata;
  assign irq        = |(s_q.irq_status & s_q.irq_mask);

  // ----------------------------------------------------------------
  // checks: reset and register map
  // ----------------------------------------------------------------
  reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
    (s_q.sleep_gate & ~scg_pkg::GATE_WMASK) == 32'h0000_0000)
    else $error("reserved sleep gate bits set");

  reset_clear_a: assert property (@(posedge clock) // [RULE3]
    !rst_n |=> s_q.sleep_gate == 32'h0000_0000)
    else $error("sleep gate not cleared by reset");

  run_reset_a: assert property (@(posedge clock) // [RULE3]
    !rst_n |=> (s_q.run_gate == 32'h0000_0000 && s_q.deep_gate == 32'h0000_0000))
    else $error("gate registers not cleared by reset");

  en_reset_a: assert property (@(posedge clock) // [RULE3]
    !rst_n |=> unit_en == 10'h000)
    else $error("unit enabled straight after reset");

  irq_reset_a: assert property (@(posedge clock) // [RULE3]
    !rst_n |=> !irq)
    else $error("interrupt high straight after reset");

  usb_write_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
    (wr && addr == scg_pkg::SLEEP_GATE_OFF) |=> s_q.sleep_gate[16] == $past(wdata[16]))
    else $error("usb enable not written");

  usb_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
    (rd && addr == scg_pkg::SLEEP_GATE_OFF && !wr) |=> rdata[16] == $past(s_q.sleep_gate[16]))
    else $error("usb enable misread");

  dma_write_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
    (wr && addr == scg_pkg::SLEEP_GATE_OFF) |=> s_q.sleep_gate[13] == $past(wdata[13]))
    else $error("dma enable not written");

  dma_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
    (rd && addr == scg_pkg::SLEEP_GATE_OFF && !wr) |=> rdata[13] == $past(s_q.sleep_gate[13]))
    else $error("dma enable misread");

  port_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
    (rd && addr == scg_pkg::SLEEP_GATE_OFF && !wr) |=> rdata[7:0] == $past(s_q.sleep_gate[7:0]))
    else $error("port enables misread");

  port_write_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
    (wr && addr == scg_pkg::SLEEP_GATE_OFF) |=> s_q.sleep_gate[7:0] == $past(wdata[7:0]))
    else $error("port enables not written");

  rsvd_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
    (rd && addr == scg_pkg::SLEEP_GATE_OFF && !wr) |=> (rdata & ~scg_pkg::GATE_WMASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  rsvd_other_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
    ((s_q.run_gate | s_q.deep_gate) & ~scg_pkg::GATE_WMASK) == 32'h0000_0000)
    else $error("reserved run or deep gate bits set");

  // ----------------------------------------------------------------
  // checks: enable selection
  // ----------------------------------------------------------------
  sleep_select_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
    (s_q.auto_sel && s_q.mode == scg_pkg::SCG_SLEEP) |-> en_now == pick(s_q.sleep_gate))
    else $error("sleep register not applied");

  run_select_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
    (s_q.mode == scg_pkg::SCG_RUN) |-> en_now == pick(s_q.run_gate))
    else $error("run register not applied in run");

  sleep_sync_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
    (s_q.sleep_s[1] && !s_q.deep_s[1]) |=> s_q.mode == scg_pkg::SCG_SLEEP)
    else $error("sleep state not entered");

  run_sync_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
    (!s_q.sleep_s[1] && !s_q.deep_s[1]) |=> s_q.mode == scg_pkg::SCG_RUN)
    else $error("run state not entered");

  no_auto_run_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
    !s_q.auto_sel |-> en_now == pick(s_q.run_gate))
    else $error("run register not applied without select");

  no_auto_deep_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
    (!s_q.auto_sel && s_q.mode == scg_pkg::SCG_DEEP) |-> en_now == pick(s_q.run_gate))
    else $error("deep register applied without select");

  // per-field mapping, written against the register bits directly
  usb_unit_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
    (s_q.auto_sel && s_q.mode == scg_pkg::SCG_SLEEP) |-> unit_en[9] == s_q.sleep_gate[16])
    else $error("usb enable mapped wrongly");

  dma_unit_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
    (s_q.auto_sel && s_q.mode == scg_pkg::SCG_SLEEP) |-> unit_en[8] == s_q.sleep_gate[13])
    else $error("dma enable mapped wrongly");

  port_unit_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
    (s_q.auto_sel && s_q.mode == scg_pkg::SCG_SLEEP) |-> unit_en[7:0] == s_q.sleep_gate[7:0])
    else $error("port enables mapped wrongly");

  deep_select_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE11]
    (s_q.auto_sel && s_q.mode == scg_pkg::SCG_DEEP) |-> en_now == pick(s_q.deep_gate))
    else $error("deep register not applied");

  deep_wins_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE11]
    s_q.deep_s[1] |=> s_q.mode == scg_pkg::SCG_DEEP)
    else $error("deep state not preferred");

  // ----------------------------------------------------------------
  // checks: faults and gated clocks
  // ----------------------------------------------------------------
  fault_gated_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
    (unit_access[0] && !en_now[0]) |=> unit_fault[0])
    else $error("no fault on gated access");

  no_fault_open_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
    (unit_access[9] && en_now[9]) |=> !unit_fault[9])
    else $error("fault on clocked unit");

  fault_quiet_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
    (unit_access == 10'h000) |=> unit_fault == 10'h000)
    else $error("fault without access");

  fault_flag_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
    (|unit_fault) |-> s_q.irq_status[scg_pkg::IRQ_FAULT_BIT])
    else $error("fault not flagged in status");

  // the low-phase latch must track the enable seen at the rising edge
  clk_follow_hi_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
    clk_en_q[9] == en_now[9])
    else $error("usb clock gate out of step");

  clk_follow_lo_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
    clk_en_q[0] == en_now[0])
    else $error("port a clock gate out of step");
endmodule

// [src/scg_pkg.sv]
package scg_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned    ADDR_W          = 12;
  localparam logic [11:0]    RUN_GATE_OFF    = 12'h108;
  localparam logic [11:0]    SLEEP_GATE_OFF  = 12'h118;
  localparam logic [11:0]    DEEP_GATE_OFF   = 12'h128;
  localparam logic [11:0]    RUN_CFG_OFF     = 12'h060;
  localparam logic [11:0]    IRQ_STATUS_OFF  = 12'h200;
  localparam logic [11:0]    IRQ_MASK_OFF    = 12'h204;
  localparam logic [11:0]    FAULT_INFO_OFF  = 12'h208;
  localparam logic [31:0]    GATE_RESET      = 32'h0000_0000;
  // usb 16, dma 13, ports h..a 7..0
  localparam logic [31:0]    GATE_WMASK      = 32'h0001_20FF;
  localparam int unsigned    USB_BIT         = 16;
  localparam int unsigned    DMA_BIT         = 13;
  localparam int unsigned    AUTO_SEL_BIT    = 27;
  localparam int unsigned    NUM_UNITS       = 10;
  // irq status bits
  localparam int unsigned    IRQ_FAULT_BIT   = 0;
  localparam int unsigned    IRQ_MODE_BIT    = 1;
  localparam logic [1:0]     IRQ_WMASK       = 2'h3;

  typedef enum logic [1:0] {
    SCG_RUN,
    SCG_SLEEP,
    SCG_DEEP
  } scg_mode_t;
endpackage

// [tb/test_scg_gate.sv]
module test_scg_gate;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clock;
  logic        rst_n;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        sleep_req;
  logic        deep_req;
  logic [9:0]  unit_access;
  logic [9:0]  unit_clk;
  logic [9:0]  unit_en;
  logic [9:0]  unit_fault;
  logic        irq;
  logic [31:0] v;
  int          num_errors = 0;
  int          n_tests = 0;

  scg_gate scg_gate_i (
    .clock       (clock),
    .rst_n       (rst_n),
    .addr        (addr),
    .wdata       (wdata),
    .wr          (wr),
    .rd          (rd),
    .rdata       (rdata),
    .sleep_req   (sleep_req),
    .deep_req    (deep_req),
    .unit_access (unit_access),
    .unit_clk    (unit_clk),
    .unit_en     (unit_en),
    .unit_fault  (unit_fault),
    .irq         (irq)
  );

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, well beyond the few dozen cycles of the sequence
  initial
  begin
    #200000;
    num_errors++;
    close_out;
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    addr = 12'h000;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    sleep_req = 1'b0;
    deep_req = 1'b0;
    unit_access = 10'h000;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(scg_pkg::SLEEP_GATE_OFF, v); chk(v, 32'h0000_0000);
    chk({22'h0, unit_en}, 32'h0);
    wr_reg(scg_pkg::SLEEP_GATE_OFF, 32'hFFFF_FFFF);
    rd_reg(scg_pkg::SLEEP_GATE_OFF, v); chk(v, 32'h0001_20FF);
    wr_reg(scg_pkg::RUN_CFG_OFF, 32'h0800_0000);
    wr_reg(scg_pkg::IRQ_MASK_OFF, 32'h0000_0001);
    sleep_req <= 1'b1;
    settle(5); chk({22'h0, unit_en}, 32'h3FF);
    @(posedge clock); #5 chk({22'h0, unit_clk}, 32'h3FF);
    #10 chk({22'h0, unit_clk}, 32'h0);
    // usb clocked: access must complete without a fault
    @(posedge clock);
    unit_access <= 10'h200;
    @(posedge clock);
    unit_access <= 10'h000;
    #1 chk({22'h0, unit_fault}, 32'h000);
    wr_reg(scg_pkg::SLEEP_GATE_OFF, 32'h0000_0001);
    settle(1); chk({22'h0, unit_en}, 32'h001);
    // port b gated, port a clocked: only b faults
    @(posedge clock); unit_access <= 10'h003;
    @(posedge clock); unit_access <= 10'h000;
    #1 chk({22'h0, unit_fault}, 32'h002);
    settle(2); chk({31'h0, irq}, 32'h1);
    rd_reg(scg_pkg::IRQ_STATUS_OFF, v);
    chk(v, 32'h0000_0003);
    settle(2); chk({31'h0, irq}, 32'h0);
    // without the select bit the run register (still zero) governs
    wr_reg(scg_pkg::RUN_CFG_OFF, 32'h0000_0000);
    settle(2); chk({22'h0, unit_en}, 32'h0);
    wr_reg(scg_pkg::RUN_CFG_OFF, 32'h0800_0000);
    settle(2); chk({22'h0, unit_en}, 32'h001);
    wr_reg(scg_pkg::DEEP_GATE_OFF, 32'h0000_2000);
    deep_req <= 1'b1;
    settle(5); chk({22'h0, unit_en}, 32'h100);
    @(posedge clock); unit_access <= 10'h200;
    @(posedge clock); unit_access <= 10'h000;
    #1 chk({22'h0, unit_fault}, 32'h200);
    rd_reg(12'h300, v); chk(v, 32'h0);
    close_out;
  end
endmodule
